//--- bench/psc_pll_setup_control_asserts.sv
`timescale 1ns/1ps
module psc_pll_setup_control_asserts (
  input wire clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire [1:0] vga_clock_select_inputs_i,
  input wire dot_tick_i,
  input wire [2:0] synth_out_tick_o,
  input wire [2:0] synth_enable_bit_o,
  input wire [2:0] loop_q_code_o,
  input wire return_clk_tick_o,
  input wire mem_clk_tick_o,
  input wire ext_clock_zero_sel_o,
  input wire video_clock_output_en_o
);
  logic [7:0] ctl_q;
  logic [7:0] src_q;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  // Shadow copies let routing be judged without seeing the body.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl_q <= 8'h00;
      src_q <= 8'h00;
    end else if (wr && wb_adr_i == 8'he4) begin
      ctl_q <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == 8'h68) begin
      src_q <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_once_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  q_code_a: assert property (
    loop_q_code_o != ctl_q[2:0] |=> loop_q_code_o == ctl_q[2:0])
    else $error("extra divider code stale");
  ext_sel_a: assert property (
    ext_clock_zero_sel_o != (src_q[2:0] == 3'h7)
    |=> ext_clock_zero_sel_o == (src_q[2:0] == 3'h7)) else $error("ext sel");
  video_clock_output_en_a: assert property (
    video_clock_output_en_o != (src_q[6:4] != 3'h7)
    |=> video_clock_output_en_o == (src_q[6:4] != 3'h7))
    else $error("video clock enable");
  mem_route_a: assert property (
    !ctl_q[4] |=> mem_clk_tick_o == $past(dot_tick_i))
    else $error("memory clock not from dot clock");
  ret_route_a: assert property (
    1'b1 |=> return_clk_tick_o ==
    $past(ctl_q[3] ? synth_out_tick_o[0] : synth_out_tick_o[2]))
    else $error("return clock source");
  pix_forced_a: assert property (
    (!vga_clock_select_inputs_i[1]) [*7] |-> synth_enable_bit_o[0])
    else $error("pixel enable not forced");
  loop_hold_a: assert property (
    (!vga_clock_select_inputs_i[1]) [*7] |-> $stable(synth_enable_bit_o[2]))
    else $error("loop enable moved");
endmodule
bind psc_pll_setup_control psc_pll_setup_control_asserts u_chk (
  .clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .vga_clock_select_inputs_i, .dot_tick_i,
  .synth_out_tick_o, .synth_enable_bit_o, .loop_q_code_o, .return_clk_tick_o,
  .mem_clk_tick_o, .ext_clock_zero_sel_o, .video_clock_output_en_o
);

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "psc_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
module testbench;
  logic clk_i = 0;
  logic resetn_i = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [1:0] sel = 2'h0;
  logic [2:0] cnt = 3'h0;
  logic rt = 0;
  logic dt = 0;
  logic [2:0] vt = 3'h0;
  logic [2:0] ft = 3'h0;
  logic [7:0] d;
  wire [31:0] rdat;
  wire ack, rck, mck, ext, ven;
  wire [17:0] refc, fbc;
  wire [5:0] postc;
  wire [2:0] en, qc;
  wire [7:0] ma, mb;
  int mismatches = 0;
  int checks = 0;
  psc_pll_setup_control u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vga_clock_select_inputs_i(sel), .ref_tick_i(rt), .vco_tick_i(vt),
    .fb_tick_i(ft), .dot_tick_i(dt), .synth_ref_code_o(refc),
    .synth_fb_code_o(fbc), .synth_post_code_o(postc),
    .synth_enable_bit_o(en), .loop_q_code_o(qc), .pump_up_o(),
    .pump_down_o(), .synth_locked_o(), .synth_out_tick_o(),
    .return_clk_tick_o(rck), .mem_clk_tick_o(mck),
    .ext_clock_zero_sel_o(ext), .video_clock_output_en_o(ven),
    .vga_mode_a_o(ma), .vga_mode_b_o(mb));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Equal reference and feedback rates so the pixel loop can lock.
  always @(posedge clk_i) begin
    cnt <= resetn_i ? cnt + 3'h1 : 3'h0;
    rt <= resetn_i && cnt[1:0] == 2'h0;
    ft <= {3{resetn_i && cnt[1:0] == 2'h2}};
    vt <= {3{resetn_i && cnt[0]}};
    dt <= resetn_i && cnt == 3'h3;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i[5:0], 2'h0};
    wdat <= {24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    d = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    bus(1'b1, i, v);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    `CHK(d, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    wt(6);
    resetn_i <= 1'b1;
    wt(1);
    `CHK(ven, 1'b1)
    rd(`PSC_IDX_SYNTH_PTR, 8'h00);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    wr(`PSC_IDX_CLK_SRC, 8'h77);
    wr(`PSC_IDX_VGA_MODE_A, 8'h80);
    wr(`PSC_IDX_VGA_MODE_B, 8'h98);
    wt(3);
    `CHK(ext, 1'b1)
    `CHK(ven, 1'b0)
    `CHK(ma, 8'h80)
    `CHK(mb, 8'h98)
    sel <= 2'h3;
    wt(8);
    wr(`PSC_IDX_SYNTH_PTR, 8'h2a);
    wr(`PSC_IDX_LOOP_PORT, 8'hf1);
    wt(3);
    `CHK(en[2], 1'b1)
    `CHK(postc[5:4], 2'h1)
    rd(`PSC_IDX_SYNTH_PTR, 8'h0a);
    sel <= 2'h0;
    wt(8);
    wr(`PSC_IDX_SYNTH_PTR, 8'h2a);
    wr(`PSC_IDX_LOOP_PORT, 8'h00);
    wr(`PSC_IDX_PIXEL_PORT, 8'h00);
    wt(3);
    `CHK(en[2], 1'b1)
    `CHK(en[0], 1'b1)
    sel <= 2'h3;
    wt(8);
    `CHK(en & 3'h5, 3'h0)
    wr(`PSC_IDX_SYNTH_PTR, 8'h2a);
    wr(`PSC_IDX_MEM_PORT, 8'h80);
    wt(3);
    `CHK(en[1], 1'b1)
    wr(`PSC_IDX_SYNTH_PTR, 8'h2a);
    wr(`PSC_IDX_MEM_PORT, 8'h00);
    wt(3);
    `CHK(en[1], 1'b0)
    sel <= 2'h0;
    wt(8);
    `CHK(en[0], 1'b1)
    wr(`PSC_IDX_MEM_LOOP_CTRL, 8'h1d);
    wt(3);
    `CHK(qc, 3'h5)
    wr(`PSC_IDX_MEM_LOOP_CTRL, 8'h18);
    rd(`PSC_IDX_MEM_LOOP_CTRL, 8'h18);
    // Leave the hard-wired VGA settings so the programmed codes reach the
    // pixel synthesizer outputs.
    sel <= 2'h3;
    wt(8);
    wr(`PSC_IDX_SYNTH_PTR, 8'h00);
    wr(`PSC_IDX_PIXEL_PORT, 8'he8);
    wr(`PSC_IDX_PIXEL_PORT, 8'h28);
    wr(`PSC_IDX_PIXEL_PORT, 8'hb0);
    wt(3);
    `CHK(refc[5:0], 6'h28)
    `CHK(fbc[5:0], 6'h28)
    `CHK(postc[1:0], 2'h0)
    rd(`PSC_IDX_SYNTH_PTR, 8'h00);
    rd(`PSC_IDX_PIXEL_PORT, 8'he8);
    wr(`PSC_IDX_SYNTH_PTR, 8'h3f);
    wr(`PSC_IDX_PIXEL_PORT, 8'h55);
    rd(`PSC_IDX_SYNTH_PTR, 8'h3f);
    for (int i = 0; i < 2000 && d[6] !== 1'b1; i++) begin
      bus(1'b0, `PSC_IDX_PIXEL_PORT, 8'h00);
    end
    `CHK(d, 8'h40)
    summarize();
  end
endmodule

//--- hdl/psc_phase_lock.v
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_phase_lock (
  input wire clk_i,
  input wire resetn_i,
  input wire enable_i,
  input wire ref_tick_i,
  input wire fb_tick_i,
  input wire [5:0] ref_code_i,
  input wire [5:0] fb_code_i,
  output reg up_o,
  output reg down_o,
  output reg locked_o
);
  reg [6:0] ref_cnt_q;
  reg [6:0] fb_cnt_q;
  reg ref_edge_q;
  reg fb_edge_q;
  reg [1:0] fb_seen_q;
  reg [7:0] clean_q;
  wire [6:0] ref_div = 7'd65 - {1'b0, ref_code_i};
  wire [6:0] fb_div = 7'd65 - {1'b0, fb_code_i};

  always @(posedge clk_i) begin
    if (!resetn_i || !enable_i) begin
      ref_cnt_q <= 7'h00;
      fb_cnt_q <= 7'h00;
      ref_edge_q <= 1'b0;
      fb_edge_q <= 1'b0;
      fb_seen_q <= 2'h0;
      clean_q <= 8'h00;
      up_o <= 1'b0;
      down_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      // Prescalers: each side yields one rising edge per (65 - code) ticks.
      ref_edge_q <= 1'b0;
      fb_edge_q <= 1'b0;
      if (ref_tick_i) begin
        if (ref_cnt_q + 7'h01 >= ref_div) begin
          ref_cnt_q <= 7'h00;
          ref_edge_q <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q + 7'h01;
        end
      end
      if (fb_tick_i) begin
        if (fb_cnt_q + 7'h01 >= fb_div) begin
          fb_cnt_q <= 7'h00;
          fb_edge_q <= 1'b1;
        end else begin
          fb_cnt_q <= fb_cnt_q + 7'h01;
        end
      end
      // Compare only the divided rising edges.
      up_o <= ref_edge_q & ~fb_edge_q;
      down_o <= fb_edge_q & ~ref_edge_q;
      // Lock means exactly one feedback edge per reference period, seen
      // over a run of periods.
      if (ref_edge_q) begin
        if (fb_seen_q + {1'b0, fb_edge_q} == 2'h1) begin
          if (clean_q != `PSC_LOCK_COUNT) begin
            clean_q <= clean_q + 8'h01;
          end
        end else begin
          clean_q <= 8'h00;
        end
        fb_seen_q <= 2'h0;
      end else if (fb_edge_q && fb_seen_q != 2'h3) begin
        fb_seen_q <= fb_seen_q + 2'h1;
      end
      locked_o <= (clean_q == `PSC_LOCK_COUNT);
    end
  end
endmodule

//--- hdl/psc_pll_setup_control.v
// Operation
// - Post-divider divides by 1, 2, 4, 8.
// - Loop synthesizer adds even divider 2 to 16.
// - Extra loop divider in control bits 2-0.
// - Compare rising edges after both prescalers.
// - Prescaler codes use low six bits only.
// - Return clock from loop or pixel synthesizer.
// - Memory clock from synthesizer or dot clock.
// - Pixel/loop disables apply only at select 1x.
// - Select 00/01 picks fixed pixel settings.
// - Pointer 0x2a aims ports at postscalers.
// - Ports 2f loop, 2d pixel; zero disables.
// - Writing 0x18 to 0x39 routes pixel clock.
// - Writing 0x77 to 0x1a picks external clock.
// - Pointer zero aims ports at reference prescalers.
// - Pointer 0x3f reads status, bit 6 lock.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_pll_setup_control #(
  parameter [7:0] VGA0_REF = 8'hc0,
  parameter [7:0] VGA0_FB = 8'h00,
  parameter [7:0] VGA0_POST = 8'h00,
  parameter [7:0] VGA1_REF = 8'hc0,
  parameter [7:0] VGA1_FB = 8'h00,
  parameter [7:0] VGA1_POST = 8'h00
) (
  input wire clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [1:0] vga_clock_select_inputs_i,
  input wire ref_tick_i,
  input wire [2:0] vco_tick_i,
  input wire [2:0] fb_tick_i,
  input wire dot_tick_i,
  output reg [17:0] synth_ref_code_o,
  output reg [17:0] synth_fb_code_o,
  output reg [5:0] synth_post_code_o,
  output reg [2:0] synth_enable_bit_o,
  output reg [2:0] loop_q_code_o,
  output wire [2:0] pump_up_o,
  output wire [2:0] pump_down_o,
  output wire [2:0] synth_locked_o,
  output wire [2:0] synth_out_tick_o,
  output reg return_clk_tick_o,
  output reg mem_clk_tick_o,
  output reg ext_clock_zero_sel_o,
  output reg video_clock_output_en_o,
  output reg [7:0] vga_mode_a_o,
  output reg [7:0] vga_mode_b_o
);
  // Software-visible state. Synthesizer order: pixel, memory, loop.
  reg [7:0] vga_mode_a_q;
  reg [7:0] vga_mode_b_q;
  reg [7:0] clk_src_q;
  reg [7:0] ptr_q;
  reg [7:0] ctrl_q;
  reg [7:0] ref_q [0:2];
  reg [7:0] fb_q [0:2];
  reg [7:0] post_q [0:2];
  reg [2:0] en_eff_q;

  // Select pins pass three flip-flops; the first is read only by the second.
  reg [1:0] sel_s1_q;
  reg [1:0] sel_s2_q;
  reg [1:0] sel_s3_q;
  reg [1:0] sel_q;

  reg [7:0] rd_d;
  wire [7:0] idx = {2'h0, wb_adr_i[7:2]};
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire vga_fixed = ~sel_q[1];
  wire [7:0] pix_ref_fix = sel_q[0] ? VGA1_REF : VGA0_REF;
  wire [7:0] pix_fb_fix = sel_q[0] ? VGA1_FB : VGA0_FB;
  wire [7:0] pix_post_fix = sel_q[0] ? VGA1_POST : VGA0_POST;
  wire [2:0] post_tick;
  wire loop_q_tick;
  integer s;

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
      sel_s3_q <= 2'h0;
      sel_q <= 2'h0;
    end else begin
      sel_s1_q <= vga_clock_select_inputs_i;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      if (sel_s2_q == sel_s3_q) begin
        sel_q <= sel_s3_q;
      end
    end
  end

  // Bus slave: one wait state, ack pulses for one cycle, read data and
  // write effects both land on the edge that raises ack.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {24'h000000, rd_d};
      end
    end
  end

  always @* begin
    rd_d = 8'h00;
    case (idx)
      `PSC_IDX_VGA_MODE_A: rd_d = vga_mode_a_q;
      `PSC_IDX_VGA_MODE_B: rd_d = vga_mode_b_q;
      `PSC_IDX_CLK_SRC: rd_d = clk_src_q;
      `PSC_IDX_SYNTH_PTR: rd_d = ptr_q;
      `PSC_IDX_MEM_LOOP_CTRL: rd_d = ctrl_q;
      default: rd_d = 8'h00;
    endcase
    for (s = 0; s < `PSC_NUM_SYN; s = s + 1) begin
      if (idx == `PSC_IDX_PIXEL_PORT + s) begin
        case (ptr_q[2*s +: 2])
          `PSC_PTR_REF: rd_d = ref_q[s];
          `PSC_PTR_FB: rd_d = fb_q[s];
          `PSC_PTR_POST: rd_d = post_q[s];
          default: rd_d = {1'b0, synth_locked_o[s], 6'h00};
        endcase
      end
    end
  end

  // Register writes. Each data port owns a two-bit field of the pointer.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      vga_mode_a_q <= `PSC_RESET_BYTE;
      vga_mode_b_q <= `PSC_RESET_BYTE;
      clk_src_q <= `PSC_RESET_BYTE;
      ptr_q <= `PSC_RESET_BYTE;
      ctrl_q <= `PSC_RESET_BYTE;
      for (s = 0; s < `PSC_NUM_SYN; s = s + 1) begin
        ref_q[s] <= `PSC_RESET_BYTE;
        fb_q[s] <= `PSC_RESET_BYTE;
        post_q[s] <= `PSC_RESET_BYTE;
      end
    end else if (wr) begin
      case (idx)
        `PSC_IDX_VGA_MODE_A: vga_mode_a_q <= wdat;
        `PSC_IDX_VGA_MODE_B: vga_mode_b_q <= wdat;
        `PSC_IDX_CLK_SRC: clk_src_q <= wdat;
        `PSC_IDX_SYNTH_PTR: ptr_q <= wdat;
        `PSC_IDX_MEM_LOOP_CTRL: ctrl_q <= wdat;
        default: ptr_q <= ptr_q;
      endcase
      for (s = 0; s < `PSC_NUM_SYN; s = s + 1) begin
        if (idx == `PSC_IDX_PIXEL_PORT + s) begin
          case (ptr_q[2*s +: 2])
            `PSC_PTR_REF: begin
              ref_q[s] <= wdat;
              ptr_q[2*s +: 2] <= `PSC_PTR_FB;
            end
            `PSC_PTR_FB: begin
              fb_q[s] <= wdat;
              ptr_q[2*s +: 2] <= `PSC_PTR_POST;
            end
            `PSC_PTR_POST: begin
              post_q[s] <= wdat;
              ptr_q[2*s +: 2] <= `PSC_PTR_REF;
            end
            default: ptr_q[2*s +: 2] <= `PSC_PTR_STATUS;
          endcase
        end
      end
    end
  end

  // Enables. The memory synthesizer follows its bit at once; the pixel and
  // loop synthesizers only pick up their bits while the select pins read
  // 1x, so a host can stage a disable without disturbing the display.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      en_eff_q <= 3'h0;
    end else begin
      en_eff_q[`PSC_SYN_MEM] <= post_q[`PSC_SYN_MEM][`PSC_ENABLE_BIT];
      if (sel_q[1]) begin
        en_eff_q[`PSC_SYN_PIXEL] <= post_q[`PSC_SYN_PIXEL][`PSC_ENABLE_BIT];
        en_eff_q[`PSC_SYN_LOOP] <= post_q[`PSC_SYN_LOOP][`PSC_ENABLE_BIT];
      end else begin
        // The hard-wired VGA settings always run the pixel synthesizer.
        en_eff_q[`PSC_SYN_PIXEL] <= 1'b1;
      end
    end
  end

  // Codes handed to the analog synthesizers.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      synth_ref_code_o <= 18'h00000;
      synth_fb_code_o <= 18'h00000;
      synth_post_code_o <= 6'h00;
      synth_enable_bit_o <= 3'h0;
      loop_q_code_o <= 3'h0;
    end else begin
      for (s = 0; s < `PSC_NUM_SYN; s = s + 1) begin
        synth_ref_code_o[6*s +: 6] <= ref_q[s][5:0];
        synth_fb_code_o[6*s +: 6] <= fb_q[s][5:0];
        synth_post_code_o[2*s +: 2] <= post_q[s][1:0];
      end
      if (vga_fixed) begin
        synth_ref_code_o[5:0] <= pix_ref_fix[5:0];
        synth_fb_code_o[5:0] <= pix_fb_fix[5:0];
        synth_post_code_o[1:0] <= pix_post_fix[1:0];
      end
      synth_enable_bit_o <= en_eff_q;
      loop_q_code_o <= ctrl_q[2:0];
    end
  end

  // Post-dividers: 2^P on every synthesizer, then 2*(Q+1) on the loop one.
  genvar g;
  generate
    for (g = 0; g < `PSC_NUM_SYN; g = g + 1) begin : g_syn
      psc_post_div u_post (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .enable_i(en_eff_q[g]),
        .tick_i(vco_tick_i[g]),
        .ratio_i(5'h01 << synth_post_code_o[2*g +: 2]),
        .tick_o(post_tick[g])
      );
      psc_phase_lock u_lock (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .enable_i(en_eff_q[g]),
        .ref_tick_i(ref_tick_i),
        .fb_tick_i(fb_tick_i[g]),
        .ref_code_i(synth_ref_code_o[6*g +: 6]),
        .fb_code_i(synth_fb_code_o[6*g +: 6]),
        .up_o(pump_up_o[g]),
        .down_o(pump_down_o[g]),
        .locked_o(synth_locked_o[g])
      );
    end
  endgenerate

  psc_post_div u_loop_q (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .enable_i(en_eff_q[`PSC_SYN_LOOP]),
    .tick_i(post_tick[`PSC_SYN_LOOP]),
    .ratio_i({1'b0, loop_q_code_o, 1'b0} + 5'h02),
    .tick_o(loop_q_tick)
  );

  assign synth_out_tick_o = {loop_q_tick, post_tick[1:0]};

  // Output routing and static configuration outputs.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      return_clk_tick_o <= 1'b0;
      mem_clk_tick_o <= 1'b0;
      ext_clock_zero_sel_o <= 1'b0;
      video_clock_output_en_o <= 1'b1;
      vga_mode_a_o <= 8'h00;
      vga_mode_b_o <= 8'h00;
    end else begin
      return_clk_tick_o <= ctrl_q[`PSC_RCLK_PIXEL_BIT] ?
        post_tick[`PSC_SYN_PIXEL] : loop_q_tick;
      // Dot clock lets the memory clock keep running while its own
      // synthesizer is stopped and reprogrammed.
      mem_clk_tick_o <= ctrl_q[`PSC_MCLK_SYNTH_BIT] ?
        post_tick[`PSC_SYN_MEM] : dot_tick_i;
      ext_clock_zero_sel_o <= (clk_src_q[2:0] == `PSC_EXT0_CODE);
      video_clock_output_en_o <=
        ~(&clk_src_q[`PSC_VIDEO_CLOCK_OUTPUT_DIS_LSB +: 3]);
      vga_mode_a_o <= vga_mode_a_q;
      vga_mode_b_o <= vga_mode_b_q;
    end
  end
endmodule

//--- hdl/psc_post_div.v
`timescale 1ns/1ps
module psc_post_div (
  input wire clk_i,
  input wire resetn_i,
  input wire enable_i,
  input wire tick_i,
  input wire [4:0] ratio_i,
  output reg tick_o
);
  reg [4:0] count_q;

  // One output pulse for every ratio_i input pulses; a ratio of one passes
  // every pulse straight through, one cycle late.
  always @(posedge clk_i) begin
    if (!resetn_i || !enable_i) begin
      count_q <= 5'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count_q + 5'h01 >= ratio_i) begin
          count_q <= 5'h00;
          tick_o <= 1'b1;
        end else begin
          count_q <= count_q + 5'h01;
        end
      end
    end
  end
endmodule

//--- shared/psc_consts.vh
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define PSC_IDX_VGA_MODE_A 8'h18
`define PSC_IDX_VGA_MODE_B 8'h19
`define PSC_IDX_CLK_SRC 8'h1a
`define PSC_IDX_SYNTH_PTR 8'h2c
`define PSC_IDX_PIXEL_PORT 8'h2d
`define PSC_IDX_MEM_PORT 8'h2e
`define PSC_IDX_LOOP_PORT 8'h2f
`define PSC_IDX_MEM_LOOP_CTRL 8'h39

// Synthesizer numbering used for every per-synthesizer vector.
`define PSC_SYN_PIXEL 0
`define PSC_SYN_MEM 1
`define PSC_SYN_LOOP 2
`define PSC_NUM_SYN 3

// Two-bit pointer field codes, one field per synthesizer.
`define PSC_PTR_REF 2'h0
`define PSC_PTR_FB 2'h1
`define PSC_PTR_POST 2'h2
`define PSC_PTR_STATUS 2'h3

// Field positions.
`define PSC_ENABLE_BIT 7
`define PSC_LOCK_BIT 6
`define PSC_CODE_W 6
`define PSC_RCLK_PIXEL_BIT 3
`define PSC_MCLK_SYNTH_BIT 4
`define PSC_VIDEO_CLOCK_OUTPUT_DIS_LSB 4
`define PSC_EXT0_CODE 3'h7

// Reset values.
`define PSC_RESET_BYTE 8'h00

// Consecutive clean comparisons before a synthesizer reports lock.
`define PSC_LOCK_COUNT 8'h10

`endif
